//--- mirq_pkg.sv
// Shared constants and event carrier for the metering interrupt status and calibration-mode block.
package mirq_pkg;

  // Register addresses on the special-function register port.
  localparam logic [7:0] MIRQ_ADDR_CALIBRATION_MODE_CONTROL = 8'h3d;
  localparam logic [7:0] MIRQ_ADDR_STL     = 8'hdc;
  localparam logic [7:0] MIRQ_ADDR_STM     = 8'hdd;

  // Reset values.
  localparam logic [7:0] MIRQ_CALIBRATION_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] MIRQ_STAT_RST    = 8'h00;
  localparam logic [7:0] MIRQ_ZERO_BYTE   = 8'h00;

  // Calibration-mode field positions.
  localparam int MIRQ_CAL_SEL_HI   = 5;
  localparam int MIRQ_CAL_SEL_LO   = 4;
  localparam int MIRQ_CAL_VGND_BIT = 3;
  localparam int MIRQ_CAL_IGND_BIT = 2;
  // Writable calibration-mode bits; bits 1:0 read as zero.
  localparam logic [7:0] MIRQ_CAL_MASK = 8'hfc;

  // Current channel select codes.
  localparam logic [1:0] MIRQ_SEL_FORCE_A = 2'h1;
  localparam logic [1:0] MIRQ_SEL_FORCE_B = 2'h2;

  // Low status register layout.
  localparam int MIRQ_STL_SUMMARY = 7;
  localparam int MIRQ_STL_FAULT   = 5;
  localparam int MIRQ_STL_RSIGN   = 4;
  localparam int MIRQ_STL_ASIGN   = 3;
  localparam int MIRQ_STL_VAIDLE  = 2;
  localparam int MIRQ_STL_RIDLE   = 1;
  localparam int MIRQ_STL_AIDLE   = 0;
  // Event flags of the low register, bits 5:0.
  localparam logic [7:0] MIRQ_STL_FLAGS = 8'h3f;

  // Mid status register layout, all eight bits are event flags.
  localparam int MIRQ_STM_PULSE2 = 7;
  localparam int MIRQ_STM_PULSE1 = 6;
  localparam int MIRQ_STM_VAOVF  = 5;
  localparam int MIRQ_STM_ROVF   = 4;
  localparam int MIRQ_STM_AOVF   = 3;
  localparam int MIRQ_STM_VAHALF = 2;
  localparam int MIRQ_STM_RHALF  = 1;
  localparam int MIRQ_STM_AHALF  = 0;

  // One-cycle event pulses from the measurement datapath.
  typedef struct packed {
    logic apparent_idle;
    logic irms_idle;
    logic reactive_idle;
    logic active_idle;
    logic pulse_two;
    logic pulse_one;
    logic apparent_ovf;
    logic reactive_ovf;
    logic active_ovf;
    logic apparent_half;
    logic reactive_half;
    logic active_half;
  } mirq_evt_t;

  // Levels whose transitions become sign and fault events.
  typedef struct packed {
    logic fault_mode;
    logic reactive_negative;
    logic active_negative;
  } mirq_lvl_t;

  // Direction selects taken from the accumulation configuration.
  typedef struct packed {
    logic fault_sel;
    logic reactive_sel;
    logic active_sel;
  } mirq_dir_t;

endpackage

//--- mirq_edge_detect.sv
// Transition detector that turns a level into a one-cycle event pulse.
`timescale 1ns/1ps
module mirq_edge_detect
  import mirq_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic level_in,
  input  wire logic fire_on_rise,
  output logic      event_q
);

  logic prev_q;
  logic seen_q;

  // The first sample only primes the history so reset never looks like a transition.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      prev_q <= level_in;
      seen_q <= 1'b1;
    end
  end

  // Fire on the selected direction only.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      event_q <= 1'b0;
    end else begin
      event_q <= seen_q && (fire_on_rise ? (!prev_q && level_in) : (prev_q && !level_in));
    end
  end

endmodule

//--- mirq_status_calibration_mode_control.sv
// Calibration-mode control and measurement interrupt status registers with summary flag.
//
// Functional notes
// R1 - Software keeps calibration bits 7:6 cleared.
// R2 - Bits 5:4 force A, B, or tamper-auto.
// R3 - Bit 3 grounds the voltage input.
// R4 - Bit 2 grounds the current inputs.
// R5 - Summary bit 7 set when enabled flag pending.
// R6 - Summary clears itself when enabled flags clear.
// R7 - Low bit 5 set on fault transition.
// R8 - Low bit 4 set on reactive sign change.
// R9 - Low bit 3 set on active sign change.
// R10 - Low bit 2 on apparent or rms no-load.
// R11 - Low bit 1 on reactive no-load.
// R12 - Low bit 0 on active no-load.
// R13 - Mid bit 7 per second pulse, even disabled.
// R14 - Mid bit 6 per first pulse, even disabled.
// R15 - Mid bits 5:3 on accumulator overflow.
// R16 - Mid bits 2:0 on accumulator half full.
// R17 - Enabled set flag raises pending core interrupt.
// R18 - Sign flag direction follows its configuration bit.
// R19 - Fault flag on entry or on return.
// R20 - Flags stay set until software clears them.
`timescale 1ns/1ps
module mirq_status_calibration_mode_control
  import mirq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  output logic            reg_rvalid_q,
  input  wire logic [7:0] irq_enable_low,
  input  wire logic [7:0] irq_enable_mid,
  input  wire mirq_dir_t  accumulation_config,
  input  wire mirq_lvl_t  meter_levels,
  input  wire mirq_evt_t  meter_events,
  input  wire logic       tamper_select_b,
  output logic            channel_b_select_q,
  output logic            voltage_input_ground_q,
  output logic            current_input_ground_q,
  output logic            measurement_irq_q
);

  logic [7:0] calibration_mode_control_q;
  logic [7:0] status_low_q;
  logic [7:0] status_low_d;
  logic [7:0] status_mid_q;
  logic [7:0] status_mid_d;
  logic [7:0] set_low;
  logic [7:0] set_mid;
  logic [7:0] clr_keep_low;
  logic [7:0] clr_keep_mid;
  logic       fault_evt;
  logic       reactive_sign_evt;
  logic       active_sign_evt;
  logic [1:0] current_channel_select;
  logic       summary_d;

  // Register writes, decoded once for the calibration register and both status registers.
  logic wr_cal;
  logic wr_stl;
  logic wr_stm;
  assign wr_cal = reg_wr && (reg_addr == MIRQ_ADDR_CALIBRATION_MODE_CONTROL);
  assign wr_stl = reg_wr && (reg_addr == MIRQ_ADDR_STL);
  assign wr_stm = reg_wr && (reg_addr == MIRQ_ADDR_STM);

  // Calibration-mode register; bits 1:0 are not stored and read back as zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      calibration_mode_control_q <= MIRQ_CALIBRATION_MODE_CONTROL_RST;
    end else if (wr_cal) begin
      calibration_mode_control_q <= reg_wdata & MIRQ_CAL_MASK;
    end
  end

  assign current_channel_select = calibration_mode_control_q[MIRQ_CAL_SEL_HI:MIRQ_CAL_SEL_LO];

  // Channel routing and input grounding, registered so the analog controls never glitch.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channel_b_select_q     <= 1'b0;
      voltage_input_ground_q <= 1'b0;
      current_input_ground_q <= 1'b0;
    end else begin
      unique case (current_channel_select)
        MIRQ_SEL_FORCE_A: channel_b_select_q <= 1'b0;                // [R2]
        MIRQ_SEL_FORCE_B: channel_b_select_q <= 1'b1;                // [R2]
        default:          channel_b_select_q <= tamper_select_b;     // [R2]
      endcase
      voltage_input_ground_q <= calibration_mode_control_q[MIRQ_CAL_VGND_BIT]; // [R3]
      current_input_ground_q <= calibration_mode_control_q[MIRQ_CAL_IGND_BIT]; // [R4]
    end
  end

  // Fault detector fires on entry when its select is zero, on return to normal when one.
  mirq_edge_detect u_fault_edge (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .level_in     (meter_levels.fault_mode),
    .fire_on_rise (!accumulation_config.fault_sel),
    .event_q      (fault_evt)
  );

  // Sign levels are high when negative, so select zero means the rising edge.
  mirq_edge_detect u_reactive_edge (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .level_in     (meter_levels.reactive_negative),
    .fire_on_rise (!accumulation_config.reactive_sel),
    .event_q      (reactive_sign_evt)
  );

  mirq_edge_detect u_active_edge (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .level_in     (meter_levels.active_negative),
    .fire_on_rise (!accumulation_config.active_sel),
    .event_q      (active_sign_evt)
  );

  // Event set vectors for the low status register.
  always_comb begin
    set_low                  = MIRQ_ZERO_BYTE;
    set_low[MIRQ_STL_FAULT]  = fault_evt;                                        // [R7] [R19]
    set_low[MIRQ_STL_RSIGN]  = reactive_sign_evt;                                // [R8] [R18]
    set_low[MIRQ_STL_ASIGN]  = active_sign_evt;                                  // [R9] [R18]
    set_low[MIRQ_STL_VAIDLE] = meter_events.apparent_idle | meter_events.irms_idle; // [R10]
    set_low[MIRQ_STL_RIDLE]  = meter_events.reactive_idle;                       // [R11]
    set_low[MIRQ_STL_AIDLE]  = meter_events.active_idle;                         // [R12]
  end

  // Event set vectors for the mid status register; pulse flags ignore the output enables.
  always_comb begin
    set_mid                  = MIRQ_ZERO_BYTE;
    set_mid[MIRQ_STM_PULSE2] = meter_events.pulse_two;     // [R13]
    set_mid[MIRQ_STM_PULSE1] = meter_events.pulse_one;     // [R14]
    set_mid[MIRQ_STM_VAOVF]  = meter_events.apparent_ovf;  // [R15]
    set_mid[MIRQ_STM_ROVF]   = meter_events.reactive_ovf;  // [R15]
    set_mid[MIRQ_STM_AOVF]   = meter_events.active_ovf;    // [R15]
    set_mid[MIRQ_STM_VAHALF] = meter_events.apparent_half; // [R16]
    set_mid[MIRQ_STM_RHALF]  = meter_events.reactive_half; // [R16]
    set_mid[MIRQ_STM_AHALF]  = meter_events.active_half;   // [R16]
  end

  // A write keeps the flags written as one and clears those written as zero.
  assign clr_keep_low = wr_stl ? reg_wdata : 8'hff;
  assign clr_keep_mid = wr_stm ? reg_wdata : 8'hff;

  // Set wins over a clear in the same cycle so no event is lost.
  assign status_low_d = ((status_low_q & clr_keep_low) | set_low) & MIRQ_STL_FLAGS; // [R20]
  assign status_mid_d = (status_mid_q & clr_keep_mid) | set_mid;                     // [R20]

  // Sticky flag storage.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_low_q <= MIRQ_STAT_RST;
      status_mid_q <= MIRQ_STAT_RST;
    end else begin
      status_low_q <= status_low_d;
      status_mid_q <= status_mid_d;
    end
  end

  // The summary follows the stored flags, so it drops on its own once all enabled flags clear.
  assign summary_d = |(status_low_q & irq_enable_low & MIRQ_STL_FLAGS) | |(status_mid_q & irq_enable_mid);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      measurement_irq_q <= 1'b0;
    end else begin
      measurement_irq_q <= summary_d; // [R5] [R6] [R17]
    end
  end

  // Read port answers one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_q  <= MIRQ_ZERO_BYTE;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          MIRQ_ADDR_CALIBRATION_MODE_CONTROL: reg_rdata_q <= calibration_mode_control_q;
          MIRQ_ADDR_STL:     reg_rdata_q <= {summary_d, status_low_q[6:0]}; // [R5]
          MIRQ_ADDR_STM:     reg_rdata_q <= status_mid_q;
          default:           reg_rdata_q <= MIRQ_ZERO_BYTE;
        endcase
      end
    end
  end

  // Checks on the guarded behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_force_a_route: assert property ( // [R2]
    current_channel_select == MIRQ_SEL_FORCE_A |=> !channel_b_select_q)
    else $error("Forced channel A not routed.");

  chk_auto_route: assert property ( // [R2]
    (current_channel_select == 2'h0 || current_channel_select == 2'h3) |=> channel_b_select_q == $past(tamper_select_b))
    else $error("Automatic channel selection not following tamper.");

  chk_ground_ctrl: assert property ( // [R3]
    calibration_mode_control_q[MIRQ_CAL_VGND_BIT] |=> voltage_input_ground_q)
    else $error("Voltage input not grounded.");

  chk_igrnd_ctrl: assert property ( // [R4]
    calibration_mode_control_q[MIRQ_CAL_IGND_BIT] |=> current_input_ground_q)
    else $error("Current input not grounded.");

  chk_summary_set: assert property ( // [R5]
    |(status_mid_q & irq_enable_mid) |=> measurement_irq_q)
    else $error("Summary missing for pending enabled flag.");

  chk_summary_clear: assert property ( // [R6]
    (status_low_q & irq_enable_low & MIRQ_STL_FLAGS) == 8'h00 && (status_mid_q & irq_enable_mid) == 8'h00
    |=> !measurement_irq_q)
    else $error("Summary stuck after flags cleared.");

  chk_pulse_flag: assert property ( // [R13]
    meter_events.pulse_two |=> status_mid_q[MIRQ_STM_PULSE2])
    else $error("Second pulse flag not set.");

  chk_sign_latch: assert property ( // [R18]
    !$past(sys_rst) && $fell(meter_levels.active_negative) && accumulation_config.active_sel
    && $stable(accumulation_config.active_sel) ##1 accumulation_config.active_sel |=> status_low_q[MIRQ_STL_ASIGN])
    else $error("Active sign return not flagged.");

  chk_set_wins: assert property ( // [R20]
    wr_stm && reg_wdata == 8'h00 && meter_events.active_ovf
    |=> status_mid_q[MIRQ_STM_AOVF] ##1 (status_mid_q[MIRQ_STM_AOVF] || ($past(wr_stm) && !$past(reg_wdata[3]))))
    else $error("Set lost against same-cycle clear.");

  chk_flag_sticky: assert property ( // [R20]
    status_low_q[MIRQ_STL_AIDLE] && !wr_stl |=> status_low_q[MIRQ_STL_AIDLE])
    else $error("Flag dropped without a clear.");

  // Forcing channel B or leaving a ground bit must take effect one cycle later as well.
  chk_force_b_route: assert property ( // [R2]
    current_channel_select == MIRQ_SEL_FORCE_B |=> channel_b_select_q)
    else $error("Forced channel B not routed.");

  chk_vgnd_release: assert property ( // [R3]
    !calibration_mode_control_q[MIRQ_CAL_VGND_BIT] |=> !voltage_input_ground_q)
    else $error("Voltage input grounded while not asked.");

  chk_igrnd_release: assert property ( // [R4]
    !calibration_mode_control_q[MIRQ_CAL_IGND_BIT] |=> !current_input_ground_q)
    else $error("Current inputs grounded while not asked.");

  // The summary must follow low flags too, and the readable copy must match the interrupt line.
  chk_summary_low: assert property ( // [R5] [R17]
    |(status_low_q & irq_enable_low & MIRQ_STL_FLAGS) |=> measurement_irq_q)
    else $error("Summary missing for pending low flag.");

  chk_summary_read: assert property ( // [R5]
    reg_rd && reg_addr == MIRQ_ADDR_STL |=> reg_rvalid_q && reg_rdata_q[MIRQ_STL_SUMMARY] == measurement_irq_q)
    else $error("Summary bit read back differs from the interrupt line.");

  // A transition seen at one edge shows as a flag two edges later.
  // The first edge after reset only primes the detector history, so it is left out.
  chk_fault_entry: assert property ( // [R7] [R19]
    !$past(sys_rst) && $rose(meter_levels.fault_mode) && !accumulation_config.fault_sel
    |-> ##2 status_low_q[MIRQ_STL_FAULT])
    else $error("Fault entry not flagged.");

  chk_fault_return: assert property ( // [R7] [R19]
    !$past(sys_rst) && $fell(meter_levels.fault_mode) && accumulation_config.fault_sel
    |-> ##2 status_low_q[MIRQ_STL_FAULT])
    else $error("Return to normal not flagged.");

  chk_reactive_sign: assert property ( // [R8] [R18]
    !$past(sys_rst) && $rose(meter_levels.reactive_negative) && !accumulation_config.reactive_sel
    |-> ##2 status_low_q[MIRQ_STL_RSIGN])
    else $error("Reactive sign loss not flagged.");

  chk_reactive_return: assert property ( // [R8] [R18]
    !$past(sys_rst) && $fell(meter_levels.reactive_negative) && accumulation_config.reactive_sel
    |-> ##2 status_low_q[MIRQ_STL_RSIGN])
    else $error("Reactive sign return not flagged.");

  chk_active_sign: assert property ( // [R9] [R18]
    !$past(sys_rst) && $rose(meter_levels.active_negative) && !accumulation_config.active_sel
    |-> ##2 status_low_q[MIRQ_STL_ASIGN])
    else $error("Active sign loss not flagged.");

  // Every one-cycle event must be stored at the next edge, whatever the enables say.
  chk_apparent_idle: assert property ( // [R10]
    meter_events.apparent_idle |=> status_low_q[MIRQ_STL_VAIDLE])
    else $error("Apparent no-load flag not set.");

  chk_irms_idle: assert property ( // [R10]
    meter_events.irms_idle |=> status_low_q[MIRQ_STL_VAIDLE])
    else $error("Current rms no-load flag not set.");

  chk_reactive_idle: assert property ( // [R11]
    meter_events.reactive_idle |=> status_low_q[MIRQ_STL_RIDLE])
    else $error("Reactive no-load flag not set.");

  chk_active_idle: assert property ( // [R12]
    meter_events.active_idle |=> status_low_q[MIRQ_STL_AIDLE])
    else $error("Active no-load flag not set.");

  chk_pulse_one: assert property ( // [R14]
    meter_events.pulse_one |=> status_mid_q[MIRQ_STM_PULSE1])
    else $error("First pulse flag not set.");

  chk_apparent_ovf: assert property ( // [R15]
    meter_events.apparent_ovf |=> status_mid_q[MIRQ_STM_VAOVF])
    else $error("Apparent overflow flag not set.");

  chk_reactive_ovf: assert property ( // [R15]
    meter_events.reactive_ovf |=> status_mid_q[MIRQ_STM_ROVF])
    else $error("Reactive overflow flag not set.");

  chk_active_ovf: assert property ( // [R15]
    meter_events.active_ovf |=> status_mid_q[MIRQ_STM_AOVF])
    else $error("Active overflow flag not set.");

  chk_apparent_half: assert property ( // [R16]
    meter_events.apparent_half |=> status_mid_q[MIRQ_STM_VAHALF])
    else $error("Apparent half-full flag not set.");

  chk_reactive_half: assert property ( // [R16]
    meter_events.reactive_half |=> status_mid_q[MIRQ_STM_RHALF])
    else $error("Reactive half-full flag not set.");

  chk_active_half: assert property ( // [R16]
    meter_events.active_half |=> status_mid_q[MIRQ_STM_AHALF])
    else $error("Active half-full flag not set.");

  // Without a write no stored flag may drop, in either register.
  chk_mid_sticky: assert property ( // [R20]
    !wr_stm |=> (status_mid_q & $past(status_mid_q)) == $past(status_mid_q))
    else $error("Mid flag dropped without a clear.");

  chk_low_sticky: assert property ( // [R20]
    !wr_stl |=> (status_low_q & $past(status_low_q)) == $past(status_low_q))
    else $error("Low flag dropped without a clear.");

  cov_fault_entry: cover property ($rose(status_low_q[MIRQ_STL_FAULT]));
  cov_irq_cycle:   cover property ($rose(measurement_irq_q) ##[1:20] $fell(measurement_irq_q));
  cov_chan_b:      cover property (current_channel_select == MIRQ_SEL_FORCE_B ##1 channel_b_select_q);
  cov_set_wins:    cover property (wr_stm && meter_events.active_ovf);
  cov_sign_return: cover property ($fell(meter_levels.active_negative) && accumulation_config.active_sel);

endmodule

//--- mirq_fix_placeholder.sv
// Companion file that holds no logic and no checks for this block.

//--- mirq_core_model.sv
// Embedded core model that reaches the calibration and status registers over the register port.
`timescale 1ns/1ps
module mirq_core_model
  import mirq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reg_rvalid_q,
  input  wire logic [7:0] reg_rdata_q,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // The port starts idle so that no strobe is seen during reset.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // A write strobe lasts one cycle; afterwards the idle bus shows inverted values, not stale ones.
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_addr  = addr;
    reg_wdata = (addr == MIRQ_ADDR_CALIBRATION_MODE_CONTROL) ? (data & 8'h3f) : data;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // A read answer is only taken while the valid pulse stands; otherwise unknown is returned.
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    reg_addr = ~reg_addr;
    data     = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hxx;
  endtask
endmodule

//--- meter_irq_status_calibration_mode_control_tb_top.sv
// Self-checking bench for the calibration-mode control and interrupt status block.
`timescale 1ns/1ps
module meter_irq_status_calibration_mode_control_tb_top
  import mirq_pkg::*;
;
  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata_q;
  logic       reg_rvalid_q;
  logic [7:0] irq_enable_low;
  logic [7:0] irq_enable_mid;
  mirq_dir_t  accumulation_config;
  mirq_lvl_t  meter_levels;
  mirq_evt_t  meter_events;
  logic       tamper_select_b;
  logic       channel_b_select_q;
  logic       voltage_input_ground_q;
  logic       current_input_ground_q;
  logic       measurement_irq_q;
  logic [7:0] rd;
  logic [7:0] exp_low;
  logic       exp_b;
  int         fails;
  int         checked;

  mirq_status_calibration_mode_control DUT (
    .clock                  (clock),
    .sys_rst                (sys_rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata_q            (reg_rdata_q),
    .reg_rvalid_q           (reg_rvalid_q),
    .irq_enable_low         (irq_enable_low),
    .irq_enable_mid         (irq_enable_mid),
    .accumulation_config    (accumulation_config),
    .meter_levels           (meter_levels),
    .meter_events           (meter_events),
    .tamper_select_b        (tamper_select_b),
    .channel_b_select_q     (channel_b_select_q),
    .voltage_input_ground_q (voltage_input_ground_q),
    .current_input_ground_q (current_input_ground_q),
    .measurement_irq_q      (measurement_irq_q)
  );

  mirq_core_model core (
    .clock        (clock),
    .reg_rvalid_q (reg_rvalid_q),
    .reg_rdata_q  (reg_rdata_q),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd)
  );

  // The clock runs at 10 MHz.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    core.rd_reg(addr, rd);
    check(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang is cut off well beyond the few hundred cycles that the tests need.
  initial begin
    #(20000 * 100);
    fails++;
    give_verdict();
  end

  // Main sequence; all inputs move on the falling edge so that sampling never races.
  initial begin
    sys_rst             = 1'b1;
    irq_enable_low      = 8'h00;
    irq_enable_mid      = 8'h00;
    accumulation_config = '0;
    meter_levels        = '0;
    meter_events        = '0;
    tamper_select_b     = 1'b0;
    fails               = 0;
    checked             = 0;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    rdchk(MIRQ_ADDR_CALIBRATION_MODE_CONTROL, MIRQ_CALIBRATION_MODE_CONTROL_RST);
    rdchk(MIRQ_ADDR_STL, MIRQ_STAT_RST);
    rdchk(MIRQ_ADDR_STM, MIRQ_STAT_RST);
    core.wr_reg(8'h10, 8'hff);
    rdchk(8'h10, 8'h00);
    $display("test reset_and_map done");
    // Every select code with both tamper choices and both ground bits.
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 2; t++) begin
        tamper_select_b = t[0];
        core.wr_reg(MIRQ_ADDR_CALIBRATION_MODE_CONTROL, {2'b00, s[1:0], t[0], ~t[0], 2'b11});
        idle(2);
        exp_b = (s[1:0] == MIRQ_SEL_FORCE_A) ? 1'b0 : (s[1:0] == MIRQ_SEL_FORCE_B) ? 1'b1 : t[0];
        check({7'h00, channel_b_select_q}, {7'h00, exp_b});
        check({6'h00, voltage_input_ground_q, current_input_ground_q}, {6'h00, t[0], ~t[0]});
        rdchk(MIRQ_ADDR_CALIBRATION_MODE_CONTROL, {2'b00, s[1:0], t[0], ~t[0], 2'b00});
      end
    end
    $display("test calibration_mode done");
    // Each event alone, with all enables off, must still latch and hold its flag.
    for (int i = 0; i < 12; i++) begin
      meter_events = mirq_evt_t'(12'h001 << i);
      @(negedge clock);
      meter_events = '0;
      idle(3);
      exp_low = (i == 11) ? 8'h04 : (i >= 8) ? (8'h01 << (i - 8)) : 8'h00;
      rdchk(MIRQ_ADDR_STL, exp_low);
      rdchk(MIRQ_ADDR_STM, (i < 8) ? (8'h01 << i) : 8'h00);
      check({7'h00, measurement_irq_q}, 8'h00);
      core.wr_reg(MIRQ_ADDR_STL, 8'h00);
      core.wr_reg(MIRQ_ADDR_STM, 8'h00);
      rdchk(MIRQ_ADDR_STM, 8'h00);
    end
    $display("test event_flags done");
    // Summary raise, partial clear and self clear.
    irq_enable_mid = 8'h80;
    meter_events   = mirq_evt_t'(12'h0c0);
    @(negedge clock);
    meter_events = '0;
    idle(2);
    check({7'h00, measurement_irq_q}, 8'h01);
    rdchk(MIRQ_ADDR_STL, 8'h80);
    core.wr_reg(MIRQ_ADDR_STM, 8'h7f);
    rdchk(MIRQ_ADDR_STM, 8'h40);
    check({7'h00, measurement_irq_q}, 8'h00);
    rdchk(MIRQ_ADDR_STL, 8'h00);
    irq_enable_mid = 8'h40;
    idle(2);
    check({7'h00, measurement_irq_q}, 8'h01);
    core.wr_reg(MIRQ_ADDR_STM, 8'h00);
    irq_enable_mid = 8'h00;
    irq_enable_low = 8'h01;
    meter_events   = mirq_evt_t'(12'h100);
    @(negedge clock);
    meter_events = '0;
    idle(2);
    check({7'h00, measurement_irq_q}, 8'h01);
    irq_enable_low = 8'hc0;
    idle(2);
    check({7'h00, measurement_irq_q}, 8'h00);
    core.wr_reg(MIRQ_ADDR_STL, 8'h00);
    irq_enable_low = 8'h00;
    // An overflow event in the very cycle of a clear must survive it.
    fork
      core.wr_reg(MIRQ_ADDR_STM, 8'h00);
      begin
        @(negedge clock);
        meter_events = mirq_evt_t'(12'h008);
        @(negedge clock);
        meter_events = '0;
      end
    join
    rdchk(MIRQ_ADDR_STM, 8'h08);
    core.wr_reg(MIRQ_ADDR_STM, 8'h00);
    rdchk(MIRQ_ADDR_STM, 8'h00);
    $display("test summary done");
    // Rise then fall of each level under both direction selects.
    for (int k = 0; k < 3; k++) begin
      for (int d = 0; d < 2; d++) begin
        accumulation_config = mirq_dir_t'(d[0] ? (3'b001 << k) : 3'b000);
        meter_levels        = mirq_lvl_t'(3'b001 << k);
        idle(4);
        rdchk(MIRQ_ADDR_STL, d[0] ? 8'h00 : (8'h08 << k));
        meter_levels = '0;
        idle(4);
        rdchk(MIRQ_ADDR_STL, 8'h08 << k);
        core.wr_reg(MIRQ_ADDR_STL, 8'h00);
      end
    end
    $display("test directions done");
    give_verdict();
  end
endmodule
